// file: src/ulc_ctrl.sv
// Purpose: Line control and enable registers
// Assumes: Engine on clk, events as pulses
// Notes:   Byte offsets; read data registered
`timescale 1ns/1ps

// What this block does
// RULE1: Receiver off flushes, clears faults
// RULE2: Disabled port: enables set at once
// RULE3: Enabled port: receiver on after sync
// RULE4: Transmitter off after queued frames
// RULE5: Enabled port: transmitter on after sync
// RULE6: Line control locked while enabled
// RULE7: Transmit parity, odd or even
// RULE8: Receive parity mismatch sets fault
// RULE9: Encoding bit selects IrDA
// RULE10: Start detect wakes on chosen events
// RULE11: Collision check follows enable
// RULE12: One or two stop bits
// RULE13: Width code sets data bits
// RULE14: Arithmetic mode: whole baud value
// RULE15: Fraction mode: split baud value
// RULE16: Baud locked while enabled, resets zero
// RULE17: IrDA pulse needs length plus two
// RULE18: Enable clear, mirrored in set
// RULE19: Enable bit positions, bit six unused
// RULE20: Sync pending is bit two, read only
// RULE21: Parity only for formats one and five
// RULE22: Zero first stop sets framing fault
// RULE23: Interrupt when flag and enable set
// RULE24: Reserved codes and bits read zero; a reserved width code keeps the old width
module ulc_ctrl
    import ulc_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // Register port
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    input  wire logic [5:0]      reg_addr,
    input  wire logic [31:0]     reg_wdata,
    input  wire logic            reg_protect,
    output logic [31:0]          reg_rdata,
    // Port wide settings
    input  wire logic            port_enabled,
    input  wire logic [2:0]      oversample_select,
    input  wire logic [3:0]      frame_format,
    // Serial engine side
    input  wire logic            tx_busy,
    input  wire logic [8:0]      tx_char,
    input  wire logic            tx_line,
    input  wire ulc_rx_char_type rx_char,
    input  wire logic            rx_overrun_evt,
    input  wire logic            rx_start_evt,
    input  wire logic            rx_done_evt,
    input  wire logic [7:0]      irq_flags,
    // Receive pin
    input  wire logic            rx_pin,
    // Configuration and results
    output ulc_cfg_type          cfg,
    output logic [15:0]          baud_int,
    output logic [2:0]           baud_fraction,
    output logic                 rx_flush,
    output logic                 tx_parity,
    output logic                 rx_line,
    output logic                 ir_pulse,
    output logic                 collision_seen,
    output logic                 wake_req,
    output logic                 irq_req
);
    // Receive pin synchroniser
    logic rx_s1_r;
    logic rx_s2_r;

    // Stored register contents
    logic [31:0] lc_r;          // Line control image, enables excluded
    logic [31:0] lc_nxt;
    logic        rx_run_r;      // Receiver running
    logic        rx_run_nxt;
    logic        tx_run_r;      // Transmitter running
    logic        tx_run_nxt;
    logic        tx_stop_r;     // Transmitter draining
    logic        tx_stop_nxt;
    logic [15:0] baud_r;
    logic [15:0] baud_nxt;
    logic [7:0]  ir_min_r;
    logic [7:0]  ir_min_nxt;
    logic [7:0]  irq_en_r;
    logic [7:0]  irq_en_nxt;

    // Enable handshake
    ulc_sync_state_type sync_st_r;
    ulc_sync_state_type sync_st_nxt;
    logic [3:0]  sync_cnt_r;
    logic [3:0]  sync_cnt_nxt;
    logic        pend_rx_r;     // Receiver start waiting
    logic        pend_rx_nxt;
    logic        pend_tx_r;     // Transmitter start waiting
    logic        pend_tx_nxt;

    // Fault flags
    logic [2:0]  fault_r;
    logic [2:0]  fault_nxt;

    // Registered outputs
    ulc_cfg_type cfg_nxt;
    logic [31:0] rdata_nxt;
    logic        flush_nxt;
    logic        txp_nxt;
    logic        coll_nxt;
    logic        wake_nxt;
    logic        irq_nxt;

    // Decodes
    logic        wr_lc;
    logic        wr_open;       // Not access protected
    logic        par_on;
    logic [3:0]  nbits;
    logic [8:0]  mask;
    logic        ir_ok;

    // Data bits per width code
    function automatic logic [3:0] width_bits(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h8;
        case (code)
            CW_9:    n = 4'h9;
            CW_5:    n = 4'h5;
            CW_6:    n = 4'h6;
            CW_7:    n = 4'h7;
            default: n = 4'h8;
        endcase
        return n; // see RULE13
    endfunction

    // True when a width code is defined
    function automatic logic width_ok(input logic [2:0] code);
        return (code == CW_8) || (code == CW_9) || (code >= CW_5);
    endfunction

    // Data bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++) begin : g_mask
            assign mask[gi] = (4'(gi) < nbits);
        end
    endgenerate

    assign nbits   = width_bits(lc_r[CHAR_MSB:CHAR_LSB]);
    assign wr_lc   = reg_wr && (reg_addr == LINE_CONTROL_OFS) && !reg_protect;
    assign wr_open = reg_wr && !reg_protect;
    assign par_on  = (frame_format == FRAME_FORMAT_PARITY)
                  || (frame_format == FRAME_FORMAT_AB_PARITY); // see RULE21

    // IrDA pulse length checker
    ulc_ir_filter u_ir_filter (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ir_on    (lc_r[IR_ENC_BIT]),
        .min_len  (ir_min_r),
        .line_in  (rx_s2_r),
        .pulse_ok (ir_ok)
    );

    // Receive pin synchroniser
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= rx_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    // Register writes and enable handshake
    always_comb begin
        lc_nxt       = lc_r;
        rx_run_nxt   = rx_run_r;
        tx_run_nxt   = tx_run_r;
        tx_stop_nxt  = tx_stop_r;
        baud_nxt     = baud_r;
        ir_min_nxt   = ir_min_r;
        irq_en_nxt   = irq_en_r;
        sync_st_nxt  = sync_st_r;
        sync_cnt_nxt = sync_cnt_r;
        pend_rx_nxt  = pend_rx_r;
        pend_tx_nxt  = pend_tx_r;
        flush_nxt    = 1'b0;
        if (wr_lc) begin
            // Format fields locked while enabled
            if (!port_enabled) begin
                lc_nxt[PAR_ODD_BIT]  = reg_wdata[PAR_ODD_BIT]; // see RULE6
                lc_nxt[IR_ENC_BIT]   = reg_wdata[IR_ENC_BIT];
                lc_nxt[SFD_WAKE_BIT] = reg_wdata[SFD_WAKE_BIT];
                lc_nxt[COLL_BIT]     = reg_wdata[COLL_BIT];
                lc_nxt[TWO_STOP_BIT] = reg_wdata[TWO_STOP_BIT];
                // Reserved width keeps the old one
                if (width_ok(reg_wdata[CHAR_MSB:CHAR_LSB])) begin
                    lc_nxt[CHAR_MSB:CHAR_LSB] = reg_wdata[CHAR_MSB:CHAR_LSB]; // see RULE24
                end
            end
            // Receiver enable bit
            if (!reg_wdata[RX_ON_BIT]) begin
                rx_run_nxt  = 1'b0;
                pend_rx_nxt = 1'b0;
                flush_nxt   = rx_run_r || pend_rx_r; // see RULE1
            end else if (!port_enabled) begin
                rx_run_nxt  = 1'b1; // see RULE2
            end else if (!rx_run_r) begin
                pend_rx_nxt = 1'b1; // see RULE3
            end
            // Transmitter enable bit
            if (!reg_wdata[TX_ON_BIT]) begin
                pend_tx_nxt = 1'b0;
                tx_stop_nxt = tx_run_r; // see RULE4
            end else if (!port_enabled) begin
                tx_run_nxt  = 1'b1; // see RULE2
                tx_stop_nxt = 1'b0;
            end else if (!tx_run_r || tx_stop_r) begin
                pend_tx_nxt = !tx_run_r; // see RULE5
                tx_stop_nxt = 1'b0;
            end
        end
        // Stop only once frames drained
        if (tx_stop_nxt && !tx_busy) begin
            tx_run_nxt  = 1'b0; // see RULE4
            tx_stop_nxt = 1'b0;
        end
        // Baud value, locked while the port runs
        if (wr_open && (reg_addr == BAUD_DIVISOR_OFS) && !port_enabled) begin
            baud_nxt = reg_wdata[15:0]; // see RULE16
        end
        if (wr_open && (reg_addr == IR_MIN_PULSE_OFS)) begin
            ir_min_nxt = reg_wdata[7:0];
        end
        // Set and clear views share one register
        if (wr_open && (reg_addr == IRQ_EN_CLR_OFS)) begin
            irq_en_nxt = irq_en_r & ~reg_wdata[7:0]; // see RULE18
        end
        if (wr_open && (reg_addr == IRQ_EN_SET_OFS)) begin
            irq_en_nxt = (irq_en_r | reg_wdata[7:0]) & IRQ_USED_MASK; // see RULE19
        end
        // Handshake: fixed latency stands in for the clock crossing
        case (sync_st_r)
            SYNC_IDLE: begin
                sync_cnt_nxt = 4'h0;
                if (pend_rx_nxt || pend_tx_nxt) begin
                    sync_st_nxt = SYNC_BUSY;
                end
            end
            SYNC_BUSY: begin
                if (!pend_rx_nxt && !pend_tx_nxt) begin
                    sync_st_nxt = SYNC_IDLE;
                end else if (sync_cnt_r == SYNC_LAST) begin
                    rx_run_nxt  = rx_run_nxt || pend_rx_nxt; // see RULE3
                    tx_run_nxt  = tx_run_nxt || pend_tx_nxt; // see RULE5
                    pend_rx_nxt = 1'b0;
                    pend_tx_nxt = 1'b0;
                    sync_st_nxt = SYNC_IDLE;
                end else begin
                    sync_cnt_nxt = sync_cnt_r + 4'h1;
                end
            end
            default: begin
                sync_st_nxt = SYNC_IDLE;
            end
        endcase
    end

    // Register the control state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lc_r       <= LINE_CONTROL_RST;
            rx_run_r   <= 1'b0;
            tx_run_r   <= 1'b0;
            tx_stop_r  <= 1'b0;
            baud_r     <= BAUD_RST;
            ir_min_r   <= IR_MIN_RST;
            irq_en_r   <= IRQ_EN_RST;
            sync_st_r  <= SYNC_IDLE;
            sync_cnt_r <= 4'h0;
            pend_rx_r  <= 1'b0;
            pend_tx_r  <= 1'b0;
        end else begin
            lc_r       <= lc_nxt;
            rx_run_r   <= rx_run_nxt;
            tx_run_r   <= tx_run_nxt;
            tx_stop_r  <= tx_stop_nxt;
            baud_r     <= baud_nxt;
            ir_min_r   <= ir_min_nxt;
            irq_en_r   <= irq_en_nxt;
            sync_st_r  <= sync_st_nxt;
            sync_cnt_r <= sync_cnt_nxt;
            pend_rx_r  <= pend_rx_nxt;
            pend_tx_r  <= pend_tx_nxt;
        end
    end

    // Faults; set beats same cycle clear
    always_comb begin
        fault_nxt = fault_r;
        if (wr_open && (reg_addr == FAULT_STAT_OFS)) begin
            fault_nxt = fault_nxt & ~reg_wdata[2:0];
        end
        if (flush_nxt) begin
            fault_nxt = 3'h0; // see RULE1
        end
        if (rx_char.valid && rx_run_r) begin
            // Even: even count of ones; odd: odd
            if (par_on && ((^(rx_char.data & mask) ^ rx_char.parity_bit)
                           != lc_r[PAR_ODD_BIT])) begin
                fault_nxt[PAR_F_BIT] = 1'b1; // see RULE8
            end
            if (!rx_char.stop1) begin
                fault_nxt[FRM_F_BIT] = 1'b1; // see RULE22
            end
        end
        if (rx_overrun_evt && rx_run_r) begin
            fault_nxt[OVR_F_BIT] = 1'b1;
        end
    end

    // Register the fault flags
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_r <= 3'h0;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    // Read data and engine results
    always_comb begin
        cfg_nxt.receiver_on          = rx_run_r;
        cfg_nxt.transmitter_on       = tx_run_r;
        cfg_nxt.parity_on            = par_on;
        cfg_nxt.parity_odd_select    = lc_r[PAR_ODD_BIT];
        cfg_nxt.ir_encoding_select   = lc_r[IR_ENC_BIT]; // see RULE9
        cfg_nxt.start_detect_wake_on = lc_r[SFD_WAKE_BIT];
        cfg_nxt.collision_check_on   = lc_r[COLL_BIT]; // see RULE11
        cfg_nxt.two_stop_select      = lc_r[TWO_STOP_BIT]; // see RULE12
        cfg_nxt.data_bits            = nbits;
        // Parity over active bits
        txp_nxt  = par_on && ((^(tx_char & mask)) ^ lc_r[PAR_ODD_BIT]); // see RULE7
        // Echo mismatch during a frame
        coll_nxt = lc_r[COLL_BIT] && tx_busy && (tx_line != rx_s2_r); // see RULE11
        // Both sources off wakes nothing
        wake_nxt = lc_r[SFD_WAKE_BIT]
                && ((irq_en_r[IRQ_RXS_BIT] && rx_start_evt)
                 || (irq_en_r[IRQ_RXC_BIT] && rx_done_evt)); // see RULE10
        irq_nxt  = |(irq_flags & irq_en_r); // see RULE23
        // Unmapped and reserved read zero
        rdata_nxt = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                LINE_CONTROL_OFS: begin
                    rdata_nxt = lc_r;
                    rdata_nxt[RX_ON_BIT] = rx_run_r;
                    rdata_nxt[TX_ON_BIT] = tx_run_r;
                end
                BAUD_DIVISOR_OFS: rdata_nxt[15:0] = baud_r;
                IR_MIN_PULSE_OFS: rdata_nxt[7:0]  = ir_min_r;
                IRQ_EN_CLR_OFS:   rdata_nxt[7:0]  = irq_en_r; // see RULE18
                IRQ_EN_SET_OFS:   rdata_nxt[7:0]  = irq_en_r;
                FAULT_STAT_OFS:   rdata_nxt[2:0]  = fault_r;
                SYNC_PEND_OFS: begin
                    rdata_nxt[SYNC_LC_BIT] = (sync_st_r == SYNC_BUSY); // see RULE20
                end
                default:          rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Every output leaves from a flip-flop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg            <= '0;
            baud_int       <= 16'h0000;
            baud_fraction  <= 3'h0;
            reg_rdata      <= 32'h00000000;
            rx_flush       <= 1'b0;
            tx_parity      <= 1'b0;
            rx_line        <= 1'b1;
            ir_pulse       <= 1'b0;
            collision_seen <= 1'b0;
            wake_req       <= 1'b0;
            irq_req        <= 1'b0;
        end else begin
            cfg            <= cfg_nxt;
            // Fraction mode splits off top bits
            if (oversample_select[0]) begin
                baud_int      <= {3'h0, baud_r[12:0]}; // see RULE15
                baud_fraction <= baud_r[15:13];
            end else begin
                baud_int      <= baud_r; // see RULE14
                baud_fraction <= 3'h0;
            end
            reg_rdata      <= rdata_nxt;
            rx_flush       <= flush_nxt;
            tx_parity      <= txp_nxt;
            rx_line        <= rx_s2_r;
            ir_pulse       <= ir_ok; // see RULE17
            collision_seen <= coll_nxt;
            wake_req       <= wake_nxt;
            irq_req        <= irq_nxt;
        end
    end
endmodule // ulc_ctrl

// file: src/ulc_ir_filter.sv
// Purpose: IrDA receive pulse length check
// Assumes: Synchronised input, active low pulses
// Notes:   Counter saturates so long pulses never wrap into a second accept
`timescale 1ns/1ps
module ulc_ir_filter
    import ulc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       ir_on,
    input  wire logic [7:0] min_len,
    // Line
    input  wire logic       line_in,
    output logic            pulse_ok
);
    logic [8:0] low_cnt_r;   // Consecutive low cycles
    logic [8:0] low_cnt_nxt;
    logic       ok_nxt;
    logic [8:0] need;        // Required length

    // Count low cycles, accept at the minimum
    always_comb begin
        need        = {1'b0, min_len} + IR_EXTRA;
        low_cnt_nxt = low_cnt_r;
        ok_nxt      = 1'b0;
        if (!ir_on || line_in) begin
            low_cnt_nxt = 9'h000;
        end else if (low_cnt_r != 9'h1FF) begin
            low_cnt_nxt = low_cnt_r + 9'h001;
            // One pulse per accepted low period
            ok_nxt      = (low_cnt_nxt == need); // see RULE17
        end
    end

    // Register counter and strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_cnt_r <= 9'h000;
            pulse_ok  <= 1'b0;
        end else begin
            low_cnt_r <= low_cnt_nxt;
            pulse_ok  <= ok_nxt;
        end
    end
endmodule // ulc_ir_filter

// file: src/ulc_pkg.sv
// Purpose: Constants and types of the line control block
// Assumes: Byte offsets, 10 MHz clock
// Notes:   All offsets, positions and counts
package ulc_pkg;
    // Register byte offsets
    localparam logic [5:0] LINE_CONTROL_OFS = 6'h04;
    localparam logic [5:0] BAUD_DIVISOR_OFS = 6'h0C;
    localparam logic [5:0] IR_MIN_PULSE_OFS = 6'h0E;
    localparam logic [5:0] IRQ_EN_CLR_OFS   = 6'h14;
    localparam logic [5:0] IRQ_EN_SET_OFS   = 6'h16;
    localparam logic [5:0] FAULT_STAT_OFS   = 6'h1A;
    localparam logic [5:0] SYNC_PEND_OFS    = 6'h1C;
    // Line control field positions
    localparam int RX_ON_BIT    = 17;
    localparam int TX_ON_BIT    = 16;
    localparam int PAR_ODD_BIT  = 13;
    localparam int IR_ENC_BIT   = 10;
    localparam int SFD_WAKE_BIT = 9;
    localparam int COLL_BIT     = 8;
    localparam int TWO_STOP_BIT = 6;
    localparam int CHAR_LSB     = 0;
    localparam int CHAR_MSB     = 2;
    // Sync pending and fault status positions
    localparam int SYNC_LC_BIT  = 2;
    localparam int PAR_F_BIT    = 0;
    localparam int FRM_F_BIT    = 1;
    localparam int OVR_F_BIT    = 2;
    // Interrupt enable positions, bit 6 unused
    localparam int IRQ_DRE_BIT  = 0;
    localparam int IRQ_TXC_BIT  = 1;
    localparam int IRQ_RXC_BIT  = 2;
    localparam int IRQ_RXS_BIT  = 3;
    localparam int IRQ_CTS_BIT  = 4;
    localparam int IRQ_BRK_BIT  = 5;
    localparam int IRQ_ERR_BIT  = 7;
    localparam logic [7:0] IRQ_USED_MASK = 8'hBF;
    // Frame formats that carry parity
    localparam logic [3:0] FRAME_FORMAT_PARITY    = 4'h1;
    localparam logic [3:0] FRAME_FORMAT_AB_PARITY = 4'h5;
    // Character width codes
    localparam logic [2:0] CW_8 = 3'h0;
    localparam logic [2:0] CW_9 = 3'h1;
    localparam logic [2:0] CW_5 = 3'h5;
    localparam logic [2:0] CW_6 = 3'h6;
    localparam logic [2:0] CW_7 = 3'h7;
    // Reset values
    localparam logic [31:0] LINE_CONTROL_RST = 32'h00000000;
    localparam logic [15:0] BAUD_RST         = 16'h0000;
    localparam logic [7:0]  IR_MIN_RST       = 8'h00;
    localparam logic [7:0]  IRQ_EN_RST       = 8'h00;
    // Pulse length offset in engine clocks
    localparam logic [8:0] IR_EXTRA = 9'h002;
    // Enable handshake time and its cycle count
    localparam int CLK_PERIOD_NS = 100;
    localparam int SYNC_TIME_NS  = 300;
    localparam int SYNC_CYCLES   = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SYNC_LAST = 4'(SYNC_CYCLES - 1);

    // Live engine configuration
    typedef struct packed {
        logic       receiver_on;
        logic       transmitter_on;
        logic       parity_on;
        logic       parity_odd_select;
        logic       ir_encoding_select;
        logic       start_detect_wake_on;
        logic       collision_check_on;
        logic       two_stop_select;
        logic [3:0] data_bits;
    } ulc_cfg_type;

    // Character from the engine
    typedef struct packed {
        logic       valid;
        logic [8:0] data;
        logic       parity_bit;
        logic       stop1;
    } ulc_rx_char_type;

    // Enable handshake states
    typedef enum logic [1:0] {
        SYNC_IDLE = 2'b01,
        SYNC_BUSY = 2'b10
    } ulc_sync_state_type;
endpackage

// file: verification/tb_ulc_ctrl.sv
// Purpose: Tests of the line control block
// Assumes: 10 MHz clock, reset held three cycles
// Notes:   Expectations from rules
`timescale 1ns/1ps
module tb_ulc_ctrl
    import ulc_pkg::*;
;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_protect = 1'b0;
    logic port_enabled = 1'b0, tx_busy = 1'b0, go = 1'b0, tx_line = 1'b1, rx_start_evt = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, lc_exp;
    logic [2:0] oversample_select = 3'h0, baud_fraction;
    logic [3:0] frame_format = 4'h0, db = 4'h8;
    logic [8:0] tx_char = 9'h000, len = 9'h000;
    logic [7:0] irq_flags = 8'h00, en;
    logic [15:0] baud_int, bv;
    logic rx_pin, rx_flush, tx_parity, rx_line, ir_pulse, collision_seen, wake_req, irq_req;
    ulc_cfg_type cfg;
    ulc_rx_char_type rx_done = '0;
    int fails = 0, n_checks = 0, hits = 0;
    logic [5:0] ofs [6] = '{LINE_CONTROL_OFS, BAUD_DIVISOR_OFS, IR_MIN_PULSE_OFS,
        IRQ_EN_SET_OFS, SYNC_PEND_OFS, 6'h08};
    always #50 clk = ~clk;
    // Accepted infrared pulses
    always @(posedge clk) if (ir_pulse === 1'b1) hits++;
    ulc_peer i_ulc_peer (.clk, .sys_rst, .go, .len, .rx_pin);
    ulc_ctrl i_ulc_ctrl (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_protect,
        .reg_rdata, .port_enabled, .oversample_select, .frame_format, .tx_busy, .tx_char,
        .tx_line, .rx_char(rx_done), .rx_overrun_evt(1'b0), .rx_start_evt,
        .rx_done_evt(1'b0), .irq_flags, .rx_pin, .cfg, .baud_int, .baud_fraction, .rx_flush,
        .tx_parity, .rx_line, .ir_pulse, .collision_seen, .wake_req, .irq_req);
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Write held through its taking edge
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 ck(reg_rdata, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Data bits per width code; reserved keeps old
    function automatic logic [3:0] dbits(input logic [2:0] c, input logic [3:0] old);
        return c == CW_8 ? 4'h8 : c == CW_9 ? 4'h9 : c >= CW_5 ? {1'b0, c} : old;
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(86699));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        en = 8'($urandom()) & IRQ_USED_MASK;
        wr(IRQ_EN_SET_OFS, {24'h0, en | 8'h40});
        rd(IRQ_EN_CLR_OFS, {24'h0, en});
        bv = 16'($urandom());
        wr(IRQ_EN_CLR_OFS, {24'h0, bv[7:0]});
        en = en & ~bv[7:0];
        rd(IRQ_EN_SET_OFS, {24'h0, en});
        irq_flags <= 8'hFF;
        reg_protect <= 1'b1;
        wr(IRQ_EN_SET_OFS, 32'hFF);
        reg_protect <= 1'b0;
        #1 ck(irq_req, |en);
        rd(IRQ_EN_SET_OFS, {24'h0, en});
        for (int c = 0; c < 8; c++) begin
            wr(LINE_CONTROL_OFS, 32'(c));
            db = dbits(3'(c), db);
            cyc(2);
            ck(cfg.data_bits, db);
        end
        wr(BAUD_DIVISOR_OFS, {16'h0, bv});
        cyc(2);
        ck(baud_int, bv);
        oversample_select <= 3'h1;
        cyc(3);
        ck({baud_fraction, baud_int}, {bv[15:13], 3'h0, bv[12:0]});
        lc_exp = 32'h00030700 | (32'($urandom()) & 32'h00002040);
        wr(LINE_CONTROL_OFS, lc_exp);
        rd(LINE_CONTROL_OFS, lc_exp);
        frame_format <= FRAME_FORMAT_PARITY;
        tx_char <= 9'($urandom());
        cyc(3);
        ck(tx_parity, ^tx_char[7:0] ^ lc_exp[PAR_ODD_BIT]);
        ck(cfg.two_stop_select, lc_exp[TWO_STOP_BIT]);
        ck({cfg.ir_encoding_select, cfg.collision_check_on}, 2'b11);
        rx_done <= {1'b1, 9'h0FF, 2'h2};
        {tx_line, tx_busy, rx_start_evt} <= 3'h3;
        cyc(1);
        {rx_done, tx_line, tx_busy, rx_start_evt} <= 15'h0004;
        ck(collision_seen, 1'b1);
        ck(wake_req, en[IRQ_RXS_BIT]);
        rd(FAULT_STAT_OFS, {30'h1, !lc_exp[PAR_ODD_BIT]});
        frame_format <= 4'h4;
        cyc(3);
        ck(tx_parity, 1'b0);
        wr(IR_MIN_PULSE_OFS, 32'h3);
        for (int k = 0; k < 2; k++) begin
            hits = 0;
            len <= 9'h004 + 9'(k);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            cyc(15);
            ck(hits, k);
        end
        port_enabled <= 1'b1;
        wr(BAUD_DIVISOR_OFS, {16'h0, ~bv});
        rd(BAUD_DIVISOR_OFS, {16'h0, bv});
        tx_busy <= 1'b1;
        wr(LINE_CONTROL_OFS, 32'h0);
        #1 ck(rx_flush, 1'b1);
        cyc(4);
        ck({cfg.transmitter_on, cfg.receiver_on}, 2'b10);
        tx_busy <= 1'b0;
        cyc(2);
        ck(cfg.transmitter_on, 1'b0);
        rd(FAULT_STAT_OFS, 32'h0);
        wr(LINE_CONTROL_OFS, 32'h00030000);
        rd(SYNC_PEND_OFS, 32'h4);
        cyc(4);
        rd(LINE_CONTROL_OFS, lc_exp);
        report_and_stop();
    end
endmodule // tb_ulc_ctrl

// file: verification/ulc_ctrl_props.sv
// Purpose: Port checks of the line control block
// Assumes: One clock, async high reset
// Notes:   Bound into every ulc_ctrl instance below
`timescale 1ns/1ps
module ulc_ctrl_props
    import ulc_pkg::*;
(
    // Clock, reset and register port
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        reg_wr,
    input wire logic [5:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_protect,
    // Settings and results
    input wire logic        port_enabled,
    input wire logic [2:0]  oversample_select,
    input wire logic        tx_busy,
    input wire logic [7:0]  irq_flags,
    input wire ulc_cfg_type cfg,
    input wire logic [15:0] baud_int,
    input wire logic        rx_flush,
    input wire logic        irq_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Accepted line control write
    wire lc = reg_wr && !reg_protect && reg_addr == LINE_CONTROL_OFS;
    a_rx_sync_wait: assert property (lc && port_enabled && reg_wdata[RX_ON_BIT] &&
        !cfg.receiver_on |=> !cfg.receiver_on [*3] ##[1:2] cfg.receiver_on)
        else $error("rx enable not synced");
    a_rx_direct_on: assert property (lc && !port_enabled && reg_wdata[RX_ON_BIT]
        |-> ##2 cfg.receiver_on) else $error("rx enable late");
    a_rx_off_flush: assert property (lc && cfg.receiver_on && !reg_wdata[RX_ON_BIT]
        |-> ##[1:2] rx_flush) else $error("no flush on receiver off");
    a_tx_drain_hold: assert property (lc && cfg.transmitter_on && tx_busy &&
        !reg_wdata[TX_ON_BIT] |=> ##1 cfg.transmitter_on) else $error("tx stopped early");
    a_baud_protect: assert property (reg_wr && reg_protect && $stable(oversample_select)
        |=> ##1 $stable(baud_int)) else $error("protected write changed baud");
    a_baud_enabled: assert property (reg_wr && port_enabled &&
        reg_addr == BAUD_DIVISOR_OFS && $stable(oversample_select) |=> ##1 $stable(baud_int))
        else $error("baud written while enabled");
    a_irq_none: assert property (irq_flags == 8'h00 |=> !irq_req)
        else $error("interrupt without flag");
    a_frac_top: assert property (oversample_select[0] && $past(oversample_select[0])
        |-> baud_int[15:13] == 3'h0) else $error("fraction in integer");
    // Main scenarios reached
    c_flush: cover property (rx_flush);
    c_irq: cover property (irq_req);
    c_sync: cover property (lc && port_enabled);
endmodule // ulc_ctrl_props
bind ulc_ctrl ulc_ctrl_props i_ulc_ctrl_props (.*);

// file: verification/ulc_peer.sv
// Purpose: Infrared sender on the receive pin
// Assumes: Pulses are active low, line idles high
// Notes:   Pulse length counted in clk cycles
`timescale 1ns/1ps
module ulc_peer (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Pulse request
    input  wire logic       go,
    input  wire logic [8:0] len,
    // Line
    output logic            rx_pin
);
    logic [8:0] cnt_r; // Low cycles still to send
    // Load on request, count down to idle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) cnt_r <= 9'h000;
        else if (go) cnt_r <= len;
        else if (cnt_r != 9'h000) cnt_r <= cnt_r - 9'h001;
    end
    // Line idles high
    assign rx_pin = (cnt_r == 9'h000);
endmodule // ulc_peer
